// *** hw/sphmc_ctrl.v ***
// static power hold mode controller: entry, hold and exit sequencing
// ------------------------------------------------------------
// Summary of operation
// ------------------------------------------------------------
// Summary of operation
// - enter hold one microsecond after request low
// - leave hold when request returns high
// - pin-only variant: pin level alone decides
// - managed variant: pin and user qualifier both
// - request is glitch filtered before use
// - registers and memories keep state in hold
// - plls are off throughout hold
// - outputs tristate unless weak pull configured
// - core-facing inputs read high during hold
// - jtag operations blocked while in hold
// - forced-high inputs released on exit
// - banks and globals released staggered on exit
// - output hold follows buffer drive on exit
// - unused feature makes pin ordinary io
`timescale 1ns/1ps
`default_nettype none
`include "sphmc_consts.vh"
module sphmc_ctrl #(
    parameter integer NUM_IO     = 8,                      // user io pins
    parameter integer NUM_BANKS  = 4,                      // io banks
    parameter integer NUM_GLOB   = 2,                      // global clocks
    parameter integer ENTRY_CYC  = `SPHMC_ENTRY_CYCLES,    // entry delay cycles
    parameter integer FILT_CYC   = `SPHMC_GLITCH_CYCLES,   // glitch filter length
    parameter integer SETTLE_CYC = `SPHMC_SETTLE_CYCLES,   // settle after exit
    parameter integer LOCK_CYC   = `SPHMC_PLL_ACQ_CYCLES   // max pll acquisition
) (
    input  wire                 i_sys_clk,         // system clock
    input  wire                 i_reset,           // async reset, high
    input  wire                 i_clk_en,          // freezes all state when low
    input  wire                 i_feature_en,      // hold feature in use
    input  wire                 i_managed_mode,    // 1: needs user qualifier
    input  wire                 i_sleep_request_n, // request pin level, low asks hold
    input  wire                 i_user_qualify,    // user logic allows transition
    input  wire                 i_pll_lock,        // pll lock indication
    input  wire                 i_gpio_out,        // core data for request pin as io
    input  wire                 i_gpio_oe,         // core enable for request pin as io
    input  wire [NUM_IO-1:0]    i_pad_in,          // pad input levels
    input  wire [NUM_IO-1:0]    i_core_out,        // core output data
    input  wire [NUM_IO-1:0]    i_core_oe,         // core output enables
    input  wire [NUM_IO-1:0]    i_weak_pull_en,    // weak pull configured
    input  wire                 i_jtag_req,        // tester operation request
    output reg                  o_in_hold,         // hold mode active
    output reg                  o_pll_enable,      // pll power enable
    output reg  [NUM_IO-1:0]    o_core_in,         // inputs presented to core
    output reg  [NUM_IO-1:0]    o_pad_out,         // pad output data
    output reg  [NUM_IO-1:0]    o_pad_oe,          // pad output enables
    output reg  [NUM_IO-1:0]    o_pad_pull_keep,   // weak pull kept active
    output reg  [NUM_BANKS-1:0] o_bank_active,     // io bank enables
    output reg  [NUM_GLOB-1:0]  o_glob_active,     // global clock enables
    output reg                  o_retain,          // state retention active
    output wire                 o_jtag_grant,      // tester operation allowed
    output reg                  o_user_clk_en,     // core clock enable gate
    output reg                  o_capture_en,      // core data capture gate
    output reg                  o_gpio_in,         // request pin as io input
    output reg                  o_gpio_out,        // request pin output data
    output reg                  o_gpio_oe          // request pin output enable
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    wire              req_sync;
    wire [NUM_IO-1:0] pad_sync;
    wire              lock_sync;
    wire              qual_sync;
    wire              jtag_sync;

    // request pin idles high, so reset must not look like a request
    sphmc_sync #(
        .WIDTH   (1),
        .RST_BIT (1'b1)
    ) i_sphmc_sync_req (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_async   (i_sleep_request_n),
        .o_sync    (req_sync)
    );

    // pads reset high to match the forced-high view the core gets in hold
    sphmc_sync #(
        .WIDTH   (NUM_IO),
        .RST_BIT (1'b1)
    ) i_sphmc_sync_pad (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_async   (i_pad_in),
        .o_sync    (pad_sync)
    );

    sphmc_sync #(
        .WIDTH   (1),
        .RST_BIT (1'b0)
    ) i_sphmc_sync_lock (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_async   (i_pll_lock),
        .o_sync    (lock_sync)
    );

    sphmc_sync #(
        .WIDTH   (1),
        .RST_BIT (1'b0)
    ) i_sphmc_sync_qual (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_async   (i_user_qualify),
        .o_sync    (qual_sync)
    );

    // tester request comes from its own clock; grant lags it by two cycles
    sphmc_sync #(
        .WIDTH   (1),
        .RST_BIT (1'b0)
    ) i_sphmc_sync_jtag (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_async   (i_jtag_req),
        .o_sync    (jtag_sync)
    );

    // ------------------------------------------------------------
    // glitch filter
    // ------------------------------------------------------------
    // level must stand FILT_CYC cycles before it is believed
    reg        req_filt_reg;
    reg [15:0] filt_cnt_reg;

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            req_filt_reg <= 1'b1;
            filt_cnt_reg <= 16'h0000;
        end else if (i_clk_en) begin
            if (req_sync == req_filt_reg) begin
                filt_cnt_reg <= 16'h0000;
            end else if (filt_cnt_reg == FILT_CYC[15:0] - 16'h0001) begin
                req_filt_reg <= req_sync;
                filt_cnt_reg <= 16'h0000;
            end else begin
                filt_cnt_reg <= filt_cnt_reg + 16'h0001;
            end
        end
    end

    // pin-only: pin alone; managed: pin and qualifier together
    wire want_hold = i_feature_en & ~req_filt_reg &
                     (~i_managed_mode | qual_sync);
    wire want_exit = req_filt_reg &
                     (~i_managed_mode | qual_sync);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    localparam [2:0] ST_RUN      = `SPHMC_ST_RUN;
    localparam [2:0] ST_ENTRY    = `SPHMC_ST_ENTRY;
    localparam [2:0] ST_HOLD     = `SPHMC_ST_HOLD;
    localparam [2:0] ST_SETTLE   = `SPHMC_ST_SETTLE;
    localparam [2:0] ST_LOCKWAIT = `SPHMC_ST_LOCKWAIT;
    localparam integer STAGES    = NUM_BANKS + NUM_GLOB;

    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [15:0] cnt_reg;
    reg [15:0] cnt_next;

    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 16'h0001;
        case (state_reg)
            ST_RUN: begin
                cnt_next = 16'h0000;
                if (want_hold) begin
                    state_next = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                if (~want_hold) begin
                    state_next = ST_RUN;
                    cnt_next   = 16'h0000;
                end else if (cnt_reg == ENTRY_CYC[15:0] - 16'h0001) begin
                    state_next = ST_HOLD;
                    cnt_next   = 16'h0000;
                end
            end
            ST_HOLD: begin
                cnt_next = 16'h0000;
                if (want_exit | ~i_feature_en) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // one bank or global released per step, never all at once
                if (cnt_reg == STAGES[15:0]) begin
                    cnt_next   = 16'h0000;
                    state_next = i_managed_mode ? ST_LOCKWAIT : ST_RUN;
                end
            end
            ST_LOCKWAIT: begin
                // lock plus settle, bounded by the worst acquisition time
                if ((lock_sync && cnt_reg >= SETTLE_CYC[15:0]) ||
                    cnt_reg == LOCK_CYC[15:0]) begin
                    state_next = ST_RUN;
                    cnt_next   = 16'h0000;
                end
            end
            default: begin
                state_next = ST_RUN;
                cnt_next   = 16'h0000;
            end
        endcase
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_RUN;
            cnt_reg   <= 16'h0000;
        end else if (i_clk_en) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire hold_now = (state_reg == ST_HOLD);
    wire settling = (state_reg == ST_SETTLE);
    wire in_ff    = hold_now | settling;
    integer k;

    assign o_jtag_grant = jtag_sync & ~in_ff;

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_in_hold       <= 1'b0;
            o_pll_enable    <= 1'b1;
            o_core_in       <= {NUM_IO{1'b1}};
            o_pad_out       <= {NUM_IO{1'b0}};
            o_pad_oe        <= {NUM_IO{1'b0}};
            o_pad_pull_keep <= {NUM_IO{1'b0}};
            o_bank_active   <= {NUM_BANKS{1'b1}};
            o_glob_active   <= {NUM_GLOB{1'b1}};
            o_retain        <= 1'b0;
            o_user_clk_en   <= 1'b1;
            o_capture_en    <= 1'b1;
            o_gpio_in       <= 1'b1;
            o_gpio_out      <= 1'b0;
            o_gpio_oe       <= 1'b0;
        end else if (i_clk_en) begin
            o_in_hold    <= hold_now;
            o_retain     <= hold_now;
            o_pll_enable <= ~in_ff;
            // forced high in hold; real level returns on exit, so a low pin falls
            o_core_in <= hold_now ? {NUM_IO{1'b1}} : pad_sync;
            // output hold tracks core drive: pad resumes from the driven value
            o_pad_out <= i_core_out;
            o_pad_oe  <= hold_now ? {NUM_IO{1'b0}} : i_core_oe;
            o_pad_pull_keep <= hold_now ? i_weak_pull_en : {NUM_IO{1'b0}};
            for (k = 0; k < NUM_BANKS; k = k + 1) begin
                o_bank_active[k] <= ~(hold_now | (settling && cnt_reg <= k));
            end
            for (k = 0; k < NUM_GLOB; k = k + 1) begin
                o_glob_active[k] <= ~(hold_now |
                    (settling && cnt_reg <= NUM_BANKS + k));
            end
            // data capture stays off until the exit has fully settled
            o_user_clk_en <= (state_next == ST_RUN) & (state_reg != ST_HOLD);
            o_capture_en  <= (state_next == ST_RUN) & (state_reg != ST_HOLD);
            // pin doubles as plain io when the feature is off
            o_gpio_in  <= i_feature_en ? 1'b1 : req_sync;
            o_gpio_out <= i_gpio_out;
            o_gpio_oe  <= ~i_feature_en & i_gpio_oe;
        end
    end

endmodule

// ------------------------------------------------------------
// two-stage synchroniser
// ------------------------------------------------------------
// only the second stage leaves this module, so a metastable first stage
// never fans out into the controller
module sphmc_sync #(
    parameter integer WIDTH   = 1,    // bits synchronised
    parameter [0:0]   RST_BIT = 1'b0  // level both stages take in reset
) (
    input  wire             i_sys_clk, // system clock
    input  wire             i_reset,   // async reset, high
    input  wire             i_clk_en,  // freezes both stages when low
    input  wire [WIDTH-1:0] i_async,   // level from outside the clock domain
    output wire [WIDTH-1:0] o_sync     // level safe to use
);

    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            s1_reg <= {WIDTH{RST_BIT}};
            s2_reg <= {WIDTH{RST_BIT}};
        end else if (i_clk_en) begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
        end
    end

    assign o_sync = s2_reg;

endmodule
`default_nettype wire

// *** hw/sphmc_consts.vh ***
// constants for the static power hold mode controller
`ifndef SPHMC_CONSTS_VH
`define SPHMC_CONSTS_VH
`define SPHMC_CLK_MHZ        200
`define SPHMC_ENTRY_DELAY_NS 1000
`define SPHMC_ENTRY_CYCLES   ((`SPHMC_ENTRY_DELAY_NS * `SPHMC_CLK_MHZ) / 1000)
`define SPHMC_GLITCH_CYCLES  16
`define SPHMC_SETTLE_CYCLES  32
`define SPHMC_PLL_ACQ_CYCLES 4000
`define SPHMC_ST_RUN         3'h0
`define SPHMC_ST_ENTRY       3'h1
`define SPHMC_ST_HOLD        3'h2
`define SPHMC_ST_SETTLE      3'h3
`define SPHMC_ST_LOCKWAIT    3'h4
`endif

// *** sim/sphmc_ctrl_sva.sv ***
// assertion checker for the power hold controller ports
`timescale 1ns/1ps
`default_nettype none
module sphmc_ctrl_sva #(
    parameter integer NUM_IO    = 8,   // user io pins
    parameter integer NUM_BANKS = 4,   // io banks
    parameter integer NUM_GLOB  = 2,   // global clocks
    parameter integer ENTRY_CYC = 200, // entry delay cycles
    parameter integer FILT_CYC  = 16   // glitch filter length
) (
    input wire logic                 i_sys_clk,         // clock
    input wire logic                 i_reset,           // async reset
    input wire logic                 i_clk_en,          // freeze when low
    input wire logic                 i_feature_en,      // hold feature on
    input wire logic                 i_managed_mode,    // qualifier needed
    input wire logic                 i_sleep_request_n, // request pin
    input wire logic                 i_user_qualify,    // user qualifier
    input wire logic [NUM_IO-1:0]    i_core_out,        // core data
    input wire logic                 o_in_hold,         // hold active
    input wire logic                 o_pll_enable,      // pll power
    input wire logic [NUM_IO-1:0]    o_core_in,         // core inputs
    input wire logic [NUM_IO-1:0]    o_pad_out,         // pad data
    input wire logic [NUM_IO-1:0]    o_pad_oe,          // pad enables
    input wire logic [NUM_BANKS-1:0] o_bank_active,     // bank enables
    input wire logic [NUM_GLOB-1:0]  o_glob_active,     // global enables
    input wire logic                 o_jtag_grant       // tester allowed
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // run lengths of a qualified request, with margin for the two sync stages
    int  lo_cnt;
    int  hi_cnt;
    int  pin_lo;
    wire go = i_feature_en && (!i_managed_mode || i_user_qualify);
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            lo_cnt <= 0;
            hi_cnt <= 0;
            pin_lo <= 0;
        end else if (i_clk_en) begin
            pin_lo <= (i_feature_en && !i_sleep_request_n) ? pin_lo + 1 : 0;
            lo_cnt <= (go && !i_sleep_request_n) ? lo_cnt + 1 : 0;
            hi_cnt <= (go && i_sleep_request_n) ? hi_cnt + 1 : 0;
        end
    end
    pll_off_a: assert property (o_in_hold |-> !o_pll_enable)
        else $error("pll powered in hold");
    core_high_a: assert property (o_in_hold |-> o_core_in == {NUM_IO{1'b1}})
        else $error("core input not high in hold");
    pad_float_a: assert property (o_in_hold |-> o_pad_oe == '0)
        else $error("pad driven in hold");
    jtag_block_a: assert property (o_in_hold |-> !o_jtag_grant)
        else $error("tester granted in hold");
    entry_early_a: assert property ($rose(o_in_hold) |->
        pin_lo >= ENTRY_CYC + FILT_CYC && lo_cnt >= ENTRY_CYC)
        else $error("hold entered too early");
    entry_due_a: assert property (lo_cnt == ENTRY_CYC + FILT_CYC + 8 |-> o_in_hold)
        else $error("hold not entered in time");
    exit_due_a: assert property (hi_cnt == FILT_CYC + 6 |-> !o_in_hold)
        else $error("hold not left in time");
    bank_first_a: assert property ($rose(o_glob_active[0]) |-> &o_bank_active)
        else $error("global released before banks");
    pad_follow_a: assert property (!$past(i_reset) && $past(i_clk_en)
        |-> o_pad_out == $past(i_core_out))
        else $error("pad data not following core");
endmodule
`default_nettype wire

// *** sim/sphmc_req_host.sv ***
// request pin driver standing in for the external controller
`timescale 1ns/1ps
`default_nettype none
module sphmc_req_host (
    input  wire logic i_sys_clk,         // bench clock
    input  wire logic i_want_hold,       // ask for hold
    input  wire logic i_glitch,          // commanded spurious inversion
    output var  logic o_sleep_request_n, // request pin
    output wire logic o_tck              // test clock
);
    logic tck_reg = 1'b0;
    // pin follows the falling-edge commands at once, so no race at that edge
    always_comb o_sleep_request_n = !(i_want_hold ^ i_glitch);
    // tck parked while hold is requested so the test logic stays idle
    always @(posedge i_sys_clk) begin
        tck_reg <= i_want_hold ? tck_reg : !tck_reg;
    end
    assign o_tck = tck_reg;
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the power hold controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk = 1'b0, rst = 1'b1, clk_en = 1'b1, feat = 1'b1, mgd = 1'b0;
    logic       qual = 1'b0, lock = 1'b0, want = 1'b0, glitch = 1'b0, rnd = 1'b1;
    logic       jreq = 1'b1, gout = 1'b0, goe = 1'b0;
    logic [7:0] pad = 8'h00, cout = 8'h00, coe = 8'h00, pull = 8'h00;
    logic [31:0] seed = 32'h000169C4;
    wire        req_n, tck, in_hold, pll_en, retain, jgrant, uclk, cap, gin, gpo, gpoe;
    wire [7:0]  core_in, pad_out, pad_oe, keep;
    wire [3:0]  banks;
    wire [1:0]  globs;
    int         num_errors = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] mask_exp(input logic h, input logic [7:0] v,
                                            input logic [7:0] f);
        return h ? f : v;
    endfunction
    always @(negedge clk) begin
        if (rnd) begin
            seed <= lfsr(seed);
            {pad, cout, coe, pull} <= seed;
            jreq <= seed[3] ^ seed[9];
        end else begin
            jreq <= 1'b1;
        end
    end
    sphmc_req_host i_sphmc_req_host (.i_sys_clk(clk), .i_want_hold(want), .i_glitch(glitch),
        .o_sleep_request_n(req_n), .o_tck(tck));
    sphmc_ctrl #(.ENTRY_CYC(4), .FILT_CYC(2), .SETTLE_CYC(2), .LOCK_CYC(20)) i_sphmc_ctrl (
        .i_sys_clk(clk), .i_reset(rst), .i_clk_en(clk_en), .i_feature_en(feat),
        .i_managed_mode(mgd), .i_sleep_request_n(req_n), .i_user_qualify(qual),
        .i_pll_lock(lock), .i_gpio_out(gout), .i_gpio_oe(goe), .i_pad_in(pad),
        .i_core_out(cout), .i_core_oe(coe), .i_weak_pull_en(pull), .i_jtag_req(jreq),
        .o_in_hold(in_hold), .o_pll_enable(pll_en), .o_core_in(core_in), .o_pad_out(pad_out),
        .o_pad_oe(pad_oe), .o_pad_pull_keep(keep), .o_bank_active(banks), .o_glob_active(globs),
        .o_retain(retain), .o_jtag_grant(jgrant), .o_user_clk_en(uclk), .o_capture_en(cap),
        .o_gpio_in(gin), .o_gpio_out(gpo), .o_gpio_oe(gpoe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_hold(input logic v);
        for (int k = 0; k < 60 && in_hold !== v; k++) @(negedge clk);
        chk({7'h00, in_hold}, {7'h00, v});
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        tally_and_finish;
    end
    initial begin
        cyc(8);
        rst = 1'b0;
        glitch = 1'b1;
        cyc(1);
        glitch = 1'b0;
        cyc(20);
        chk({7'h00, in_hold}, 8'h00);
        want = 1'b1;
        wait_hold(1'b1);
        rnd = 1'b0;
        // a frozen clock enable must not disturb the held state
        clk_en = 1'b0;
        cyc(5);
        clk_en = 1'b1;
        cyc(4);
        chk({5'h00, pll_en, retain, jgrant}, 8'h02);
        chk(pad_oe, mask_exp(1'b1, coe, 8'h00));
        chk(keep, pull);
        chk(core_in, mask_exp(1'b1, pad, 8'hFF));
        chk(pad_out, cout);
        want = 1'b0;
        wait_hold(1'b0);
        cyc(10);
        chk({2'b00, banks, globs}, 8'h3F);
        chk(core_in, mask_exp(1'b0, pad, 8'hFF));
        chk(pad_oe, mask_exp(1'b0, coe, 8'h00));
        chk({7'h00, jgrant}, 8'h01);
        rnd = 1'b1;
        mgd = 1'b1;
        want = 1'b1;
        cyc(40);
        chk({7'h00, in_hold}, 8'h00);
        qual = 1'b1;
        wait_hold(1'b1);
        qual = 1'b0;
        want = 1'b0;
        cyc(30);
        chk({7'h00, in_hold}, 8'h01);
        qual = 1'b1;
        wait_hold(1'b0);
        cyc(10);
        chk({6'h00, uclk, cap}, 8'h00);
        lock = 1'b1;
        cyc(10);
        chk({6'h00, uclk, cap}, 8'h03);
        mgd = 1'b0;
        cyc(30);
        feat = 1'b0;
        goe = 1'b1;
        gout = 1'b1;
        want = 1'b1;
        cyc(40);
        chk({4'h0, in_hold, gin, gpo, gpoe}, 8'h03);
        want = 1'b0;
        feat = 1'b1;
        cyc(30);
        tally_and_finish;
    end
endmodule
bind sphmc_ctrl sphmc_ctrl_sva #(.NUM_IO(NUM_IO), .NUM_BANKS(NUM_BANKS), .NUM_GLOB(NUM_GLOB),
    .ENTRY_CYC(ENTRY_CYC), .FILT_CYC(FILT_CYC)) i_sphmc_ctrl_sva (.i_sys_clk, .i_reset,
    .i_clk_en, .i_feature_en, .i_managed_mode, .i_sleep_request_n, .i_user_qualify,
    .i_core_out, .o_in_hold, .o_pll_enable, .o_core_in, .o_pad_out, .o_pad_oe,
    .o_bank_active, .o_glob_active, .o_jtag_grant);
`default_nettype wire
